// ---- hw/tcc_params.svh ----
// offsets, field positions and reset values of the timer counter control core
// assumes: included by bare name by every design file that needs a number
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// register indices; byte address is four times the index
`define TCC_IDX_SELECT      8'h00
`define TCC_IDX_EV7_MASK    8'h02
`define TCC_IDX_EV7_DATA    8'h03
`define TCC_IDX_COUNTER     8'h04
`define TCC_IDX_COUNTER_LO  8'h05
`define TCC_IDX_CONTROL_ONE 8'h06
`define TCC_IDX_TOGGLE      8'h07
`define TCC_IDX_CONTROL_TWO 8'h0D
`define TCC_IDX_CHAN_FLAGS  8'h0E
`define TCC_IDX_OVF_FLAGS   8'h0F
`define TCC_IDX_CHAN_FIRST  8'h10
`define TCC_IDX_CHAN_LAST   8'h1F
`define TCC_IDX_PA_FLAGS    8'h21
`define TCC_IDX_PA_COUNT_HI 8'h22
`define TCC_IDX_PA_COUNT_LO 8'h23
`define TCC_IDX_DISCONNECT  8'h2C
`define TCC_IDX_PRECISION   8'h2D

// control one fields
`define TCC_BIT_ENABLE      7
`define TCC_BIT_STOP_WAIT   6
`define TCC_BIT_STOP_FREEZE 5
`define TCC_BIT_FAST_CLEAR  4
`define TCC_BIT_PRECISION   3
// control two legacy prescale field
`define TCC_LEGACY_MSB      2
// flag positions
`define TCC_BIT_OVF_FLAG    7
`define TCC_BIT_PA_OVF      1
`define TCC_BIT_PA_INPUT    0

// reset values
`define TCC_RST_BYTE        8'h00
`define TCC_RST_COUNT       16'h0000
`define TCC_COUNT_MAX       16'hFFFF

// pulse accumulator clock division
`define TCC_PA_DIVIDE       64
`endif

// ---- hw/tcc_pkg.sv ----
// types shared by the timer counter control core and its prescaler
// assumes: compiled before any design module
package tcc_pkg;
	typedef logic [7:0]  tcc_byte_t;
	typedef logic [15:0] tcc_count_t;
	typedef logic [31:0] tcc_word_t;
	typedef enum logic [0:0] {
		TCC_PRE_LEGACY    = 1'b0,
		TCC_PRE_PRECISION = 1'b1
	} tcc_pre_src_t;
endpackage

// ---- hw/tcc_prescaler.sv ----
// prescaler: counter tick at a programmable ratio and the divide-by-64 clock
// assumes: single clock hclk, ratio given as ratio minus one
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"

module tcc_prescaler #(
	parameter int RATIO_W = 8,
	parameter int PA_DIV  = `TCC_PA_DIVIDE
) (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// control
	input  wire logic               run,
	input  wire logic               pa_run,
	input  wire logic [RATIO_W-1:0] ratio_m1,
	// ticks
	output logic                    count_tick,
	output logic                    pa_tick
);
	import tcc_pkg::*;

	localparam int PA_W = $clog2(PA_DIV);

	initial begin
		if (RATIO_W < 1 || PA_DIV < 2 || (1 << PA_W) != PA_DIV)
			$error("tcc_prescaler: bad parameters");
	end

	logic [RATIO_W-1:0] div_cnt;
	logic [RATIO_W-1:0] next_div_cnt;
	logic [PA_W-1:0]    pa_cnt;
	logic [PA_W-1:0]    next_pa_cnt;
	logic               next_pa_tick;
	logic               pa_tick_q;

	// gated so a tick registered just before a stop never leaks out
	assign pa_tick = pa_run && pa_tick_q;

	// >= so a ratio lowered below the running count cannot skip a wrap
	assign count_tick = run && (div_cnt >= ratio_m1);

	always_comb begin
		next_div_cnt = div_cnt;
		next_pa_cnt  = pa_cnt;
		next_pa_tick = 1'b0;
		if (run)
			next_div_cnt = count_tick ? '0 : div_cnt + 1'b1;
		if (pa_run) begin
			next_pa_cnt  = pa_cnt + 1'b1;
			next_pa_tick = (pa_cnt == PA_W'(PA_DIV - 1));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
			pa_cnt  <= '0;
			pa_tick_q <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			pa_cnt  <= next_pa_cnt;
			pa_tick_q <= next_pa_tick;
		end
	end
endmodule
`default_nettype wire

// ---- hw/tcc_core.sv ----
// timer counter control core: main counter, control one, channel 7 event, toggles
// assumes: AHB-Lite single word transfers, mode levels from hclk-domain logic
//
// Summary of operation
// - channel 7 event copies data bits through mask
// - main counter is 16-bit, counts up only
// - counter writes only in test mode
// - first period after counter write may vary
// - enable bit zero stops counter and timer
// - no divide-by-64 clock while timer inactive
// - stop-in-wait halts timer and pulse accumulator
// - stop-in-freeze halts counter, not accumulator
// - fast clear: capture register read or compare register write clears flag
// - fast clear: counter access clears overflow flag
// - fast clear: accumulator count access clears flags
// - precision bit picks prescaler ratio source
// - precision bit accepts first write only
// - overflow toggles compare pins when enabled
// - toggle beats forced compare, yields to channel 7
// - channel 7 drive needs compare mode, connected
// - select bit one means output compare
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"

module tcc_core (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output tcc_pkg::tcc_word_t     hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// system modes
	input  wire logic              test_mode,
	input  wire logic              wait_mode,
	input  wire logic              freeze_mode,
	// channel logic events
	input  wire tcc_pkg::tcc_byte_t compare_match,
	input  wire tcc_pkg::tcc_byte_t capture_event,
	input  wire tcc_pkg::tcc_byte_t chan_action,
	input  wire tcc_pkg::tcc_byte_t chan_action_level,
	// pulse accumulator events
	input  wire logic              pa_overflow_event,
	input  wire logic              pa_input_event,
	// timer port pins
	output tcc_pkg::tcc_byte_t     timer_pin_out,
	output tcc_pkg::tcc_byte_t     timer_pin_oe_n,
	// to the rest of the timer
	output tcc_pkg::tcc_count_t    main_counter,
	output logic                   count_tick,
	output logic                   pa_div64_tick,
	output tcc_pkg::tcc_byte_t     channel_compare_select,
	output tcc_pkg::tcc_byte_t     channel_event_flag,
	output logic                   counter_overflow_flag,
	output logic                   pulse_accum_overflow_flag,
	output logic                   pulse_accum_input_flag
);
	import tcc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	tcc_byte_t    channel7_event_mask,   next_mask;
	tcc_byte_t    channel7_event_data,   next_data7;
	tcc_byte_t    overflow_toggle_enables, next_tov;
	tcc_byte_t    compare_pin_disconnect, next_disc;
	tcc_byte_t    precision_prescaler_register, next_ppr;
	logic [2:0]   legacy_prescale,       next_legacy;
	logic         timer_enable_bit,      next_ten;
	logic         stop_in_wait_bit,      next_swai;
	logic         stop_in_freeze_bit,    next_sfrz;
	logic         fast_clear_bit,        next_ffca;
	tcc_pre_src_t precision_prescale_select, next_precision_prescale_select;
	logic         precision_prescale_select_locked,           next_precision_prescale_select_locked;
	tcc_count_t   next_counter;
	tcc_byte_t    next_select, next_chan_flags, next_pins, next_oe_n;
	logic         next_ovf_flag, next_pa_ovf, next_pa_in;
	tcc_word_t    next_hrdata;
	logic         dp_valid, next_dp_valid;
	logic         dp_write, next_dp_write;
	logic [7:0]   dp_idx,   next_dp_idx;

	logic         ap_take;
	logic [7:0]   ap_idx;
	logic         wr, rd;
	logic         count_run, pa_run, overflow, ev7, cnt_write;
	logic [7:0]   ratio_m1;
	tcc_byte_t    drive_ok, ev7_bits, tov_bits, chan_clr, fast_chan_clr;

	function automatic logic is_chan_reg(input logic [7:0] idx);
		return idx >= `TCC_IDX_CHAN_FIRST && idx <= `TCC_IDX_CHAN_LAST;
	endfunction

	function automatic logic is_idx(input logic [7:0] idx, input logic [7:0] want);
		return idx == want;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus decode; zero wait, always okay

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && hready && htrans[1];
	assign ap_idx    = haddr[9:2];
	assign wr        = dp_valid && dp_write;
	assign rd        = dp_valid && !dp_write;

	////////////////////////////////////////////////////////////////////////////////
	// timing chain

	assign count_run = timer_enable_bit && !(stop_in_wait_bit && wait_mode)
		&& !(stop_in_freeze_bit && freeze_mode);
	assign pa_run    = timer_enable_bit && !(stop_in_wait_bit && wait_mode);
	assign ratio_m1  = (precision_prescale_select == TCC_PRE_PRECISION)
		? precision_prescaler_register : ((8'h01 << legacy_prescale) - 8'h01);

	// counter write leaves prescaler phase alone, so the next period is uneven
	tcc_prescaler #(
		.RATIO_W (8),
		.PA_DIV  (`TCC_PA_DIVIDE)
	) u_prescaler (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.run        (count_run),
		.pa_run     (pa_run),
		.ratio_m1   (ratio_m1),
		.count_tick (count_tick),
		.pa_tick    (pa_div64_tick)
	);

	assign cnt_write = wr && is_idx(dp_idx, `TCC_IDX_COUNTER) && test_mode;
	assign overflow  = count_tick && !cnt_write && main_counter == `TCC_COUNT_MAX;

	////////////////////////////////////////////////////////////////////////////////
	// pin events

	assign drive_ok = channel_compare_select & ~compare_pin_disconnect;
	assign ev7      = (overflow && overflow_toggle_enables[7])
		|| (compare_match[7] && channel_compare_select[7]);
	assign ev7_bits = ev7 ? (channel7_event_mask & drive_ok) : 8'h00;
	assign tov_bits = overflow ? (overflow_toggle_enables & channel_compare_select) : 8'h00;

	// fast clear on channel registers: read of capture, write of compare
	always_comb begin
		fast_chan_clr = 8'h00;
		if (fast_clear_bit && dp_valid && is_chan_reg(dp_idx)) begin
			if (dp_write && channel_compare_select[dp_idx[3:1]])
				fast_chan_clr[dp_idx[3:1]] = 1'b1;
			if (!dp_write && !channel_compare_select[dp_idx[3:1]])
				fast_chan_clr[dp_idx[3:1]] = 1'b1;
		end
	end
	assign chan_clr = fast_clear_bit ? fast_chan_clr
		: ((wr && is_idx(dp_idx, `TCC_IDX_CHAN_FLAGS)) ? hwdata[7:0] : 8'h00);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_mask        = channel7_event_mask;
		next_data7       = channel7_event_data;
		next_tov         = overflow_toggle_enables;
		next_disc        = compare_pin_disconnect;
		next_ppr         = precision_prescaler_register;
		next_legacy      = legacy_prescale;
		next_select      = channel_compare_select;
		next_ten         = timer_enable_bit;
		next_swai        = stop_in_wait_bit;
		next_sfrz        = stop_in_freeze_bit;
		next_ffca        = fast_clear_bit;
		next_precision_prescale_select        = precision_prescale_select;
		next_precision_prescale_select_locked = precision_prescale_select_locked;
		next_counter     = count_tick ? main_counter + 16'h0001 : main_counter;
		next_dp_valid    = ap_take;
		next_dp_write    = hwrite;
		next_dp_idx      = ap_take ? ap_idx : dp_idx;
		next_hrdata      = hrdata;
		if (wr) begin
			unique case (dp_idx)
				`TCC_IDX_SELECT:      next_select = hwdata[7:0];
				`TCC_IDX_EV7_MASK:    next_mask   = hwdata[7:0];
				`TCC_IDX_EV7_DATA:    next_data7  = hwdata[7:0];
				`TCC_IDX_TOGGLE:      next_tov    = hwdata[7:0];
				`TCC_IDX_DISCONNECT:  next_disc   = hwdata[7:0];
				`TCC_IDX_PRECISION:   next_ppr    = hwdata[7:0];
				`TCC_IDX_CONTROL_TWO: next_legacy = hwdata[`TCC_LEGACY_MSB:0];
				`TCC_IDX_COUNTER: begin
					if (test_mode)
						next_counter = hwdata[15:0];
				end
				`TCC_IDX_CONTROL_ONE: begin
					next_ten  = hwdata[`TCC_BIT_ENABLE];
					next_swai = hwdata[`TCC_BIT_STOP_WAIT];
					next_sfrz = hwdata[`TCC_BIT_STOP_FREEZE];
					next_ffca = hwdata[`TCC_BIT_FAST_CLEAR];
					if (!precision_prescale_select_locked)
						next_precision_prescale_select = tcc_pre_src_t'(hwdata[`TCC_BIT_PRECISION]);
					next_precision_prescale_select_locked = 1'b1;
				end
				default: ;
			endcase
		end
		if (ap_take && !hwrite) begin
			unique case (ap_idx)
				`TCC_IDX_SELECT:      next_hrdata = {24'h00_0000, channel_compare_select};
				`TCC_IDX_EV7_MASK:    next_hrdata = {24'h00_0000, channel7_event_mask};
				`TCC_IDX_EV7_DATA:    next_hrdata = {24'h00_0000, channel7_event_data};
				`TCC_IDX_COUNTER:     next_hrdata = {16'h0000, main_counter};
				`TCC_IDX_COUNTER_LO:  next_hrdata = {24'h00_0000, main_counter[7:0]};
				`TCC_IDX_CONTROL_ONE: next_hrdata = {24'h00_0000, timer_enable_bit,
					stop_in_wait_bit, stop_in_freeze_bit, fast_clear_bit,
					precision_prescale_select, 3'b000};
				`TCC_IDX_TOGGLE:      next_hrdata = {24'h00_0000, overflow_toggle_enables};
				`TCC_IDX_CONTROL_TWO: next_hrdata = {29'h0000_0000, legacy_prescale};
				`TCC_IDX_CHAN_FLAGS:  next_hrdata = {24'h00_0000, channel_event_flag};
				`TCC_IDX_OVF_FLAGS:   next_hrdata = {24'h00_0000, counter_overflow_flag, 7'h00};
				`TCC_IDX_PA_FLAGS:    next_hrdata = {30'h0000_0000,
					pulse_accum_overflow_flag, pulse_accum_input_flag};
				`TCC_IDX_DISCONNECT:  next_hrdata = {24'h00_0000, compare_pin_disconnect};
				`TCC_IDX_PRECISION:   next_hrdata = {24'h00_0000, precision_prescaler_register};
				default:              next_hrdata = 32'h0000_0000;
			endcase
		end
		// flags: a set in the clearing cycle wins
		next_chan_flags = (channel_event_flag & ~chan_clr)
			| (compare_match & channel_compare_select)
			| (capture_event & ~channel_compare_select);
		next_ovf_flag = counter_overflow_flag;
		next_pa_ovf   = pulse_accum_overflow_flag;
		next_pa_in    = pulse_accum_input_flag;
		if (fast_clear_bit) begin
			if (dp_valid && (is_idx(dp_idx, `TCC_IDX_COUNTER)
				|| is_idx(dp_idx, `TCC_IDX_COUNTER_LO)))
				next_ovf_flag = 1'b0;
			if (dp_valid && (is_idx(dp_idx, `TCC_IDX_PA_COUNT_HI)
				|| is_idx(dp_idx, `TCC_IDX_PA_COUNT_LO))) begin
				next_pa_ovf = 1'b0;
				next_pa_in  = 1'b0;
			end
		end else begin
			if (wr && is_idx(dp_idx, `TCC_IDX_OVF_FLAGS) && hwdata[`TCC_BIT_OVF_FLAG])
				next_ovf_flag = 1'b0;
			if (wr && is_idx(dp_idx, `TCC_IDX_PA_FLAGS)) begin
				if (hwdata[`TCC_BIT_PA_OVF])
					next_pa_ovf = 1'b0;
				if (hwdata[`TCC_BIT_PA_INPUT])
					next_pa_in = 1'b0;
			end
		end
		next_ovf_flag = next_ovf_flag || overflow;
		next_pa_ovf   = next_pa_ovf || pa_overflow_event;
		next_pa_in    = next_pa_in || pa_input_event;
		// pin priority: channel 7 event, then toggle, then compare or force
		next_pins = timer_pin_out;
		for (int i = 0; i < 8; i++) begin
			if (ev7_bits[i])
				next_pins[i] = channel7_event_data[i];
			else if (tov_bits[i])
				next_pins[i] = ~timer_pin_out[i];
			else if (chan_action[i] && drive_ok[i])
				next_pins[i] = chan_action_level[i];
		end
		next_oe_n = ~drive_ok;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel7_event_mask          <= `TCC_RST_BYTE;
			channel7_event_data          <= `TCC_RST_BYTE;
			overflow_toggle_enables      <= `TCC_RST_BYTE;
			compare_pin_disconnect       <= `TCC_RST_BYTE;
			precision_prescaler_register <= `TCC_RST_BYTE;
			legacy_prescale              <= 3'b000;
			channel_compare_select       <= `TCC_RST_BYTE;
			timer_enable_bit             <= 1'b0;
			stop_in_wait_bit             <= 1'b0;
			stop_in_freeze_bit           <= 1'b0;
			fast_clear_bit               <= 1'b0;
			precision_prescale_select    <= TCC_PRE_LEGACY;
			precision_prescale_select_locked                  <= 1'b0;
			main_counter                 <= `TCC_RST_COUNT;
			channel_event_flag           <= `TCC_RST_BYTE;
			counter_overflow_flag        <= 1'b0;
			pulse_accum_overflow_flag    <= 1'b0;
			pulse_accum_input_flag       <= 1'b0;
			timer_pin_out                <= `TCC_RST_BYTE;
			timer_pin_oe_n               <= 8'hFF;
			hrdata                       <= 32'h0000_0000;
			dp_valid                     <= 1'b0;
			dp_write                     <= 1'b0;
			dp_idx                       <= 8'h00;
		end else begin
			channel7_event_mask          <= next_mask;
			channel7_event_data          <= next_data7;
			overflow_toggle_enables      <= next_tov;
			compare_pin_disconnect       <= next_disc;
			precision_prescaler_register <= next_ppr;
			legacy_prescale              <= next_legacy;
			channel_compare_select       <= next_select;
			timer_enable_bit             <= next_ten;
			stop_in_wait_bit             <= next_swai;
			stop_in_freeze_bit           <= next_sfrz;
			fast_clear_bit               <= next_ffca;
			precision_prescale_select    <= next_precision_prescale_select;
			precision_prescale_select_locked                  <= next_precision_prescale_select_locked;
			main_counter                 <= next_counter;
			channel_event_flag           <= next_chan_flags;
			counter_overflow_flag        <= next_ovf_flag;
			pulse_accum_overflow_flag    <= next_pa_ovf;
			pulse_accum_input_flag       <= next_pa_in;
			timer_pin_out                <= next_pins;
			timer_pin_oe_n               <= next_oe_n;
			hrdata                       <= next_hrdata;
			dp_valid                     <= next_dp_valid;
			dp_write                     <= next_dp_write;
			dp_idx                       <= next_dp_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wrap;
		count_tick && !cnt_write && main_counter == `TCC_COUNT_MAX;
	endsequence
	sequence s_wrapped;
		main_counter == `TCC_RST_COUNT && counter_overflow_flag;
	endsequence

	property p_count_up;
		count_tick && !cnt_write |=> main_counter == $past(main_counter) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step up");

	property p_wrap;
		s_wrap |=> s_wrapped;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap without zero and flag");

	property p_write_normal;
		wr && dp_idx == `TCC_IDX_COUNTER && !test_mode && !count_tick |=> $stable(main_counter);
	endproperty
	a_write_normal: assert property (p_write_normal) else $error("counter written in normal mode");

	property p_disabled;
		!timer_enable_bit |-> !count_tick && !pa_div64_tick ##1 !timer_enable_bit || !pa_div64_tick;
	endproperty
	a_disabled: assert property (p_disabled) else $error("timer ran while disabled");

	property p_no_pa_clock;
		!pa_run [*2] |-> !pa_div64_tick;
	endproperty
	a_no_pa_clock: assert property (p_no_pa_clock) else $error("pa clock while inactive");

	property p_wait_stop;
		stop_in_wait_bit && wait_mode |-> !count_tick && !pa_run;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("timer ran in wait");

	property p_freeze_stop;
		stop_in_freeze_bit && freeze_mode |-> !count_tick && pa_run == (timer_enable_bit
			&& !(stop_in_wait_bit && wait_mode));
	endproperty
	a_freeze_stop: assert property (p_freeze_stop) else $error("freeze handling wrong");

	property p_precision_prescale_select_once;
		wr && dp_idx == `TCC_IDX_CONTROL_ONE && precision_prescale_select_locked |=> $stable(precision_prescale_select);
	endproperty
	a_precision_prescale_select_once: assert property (p_precision_prescale_select_once) else $error("precision bit rewritten");

	property p_ev7;
		ev7 |=> ((timer_pin_out ^ $past(channel7_event_data))
			& $past(channel7_event_mask & drive_ok)) == 8'h00;
	endproperty
	a_ev7: assert property (p_ev7) else $error("channel 7 data not on pins");

	property p_toggle;
		overflow |=> ((timer_pin_out ^ ~$past(timer_pin_out)) & $past(tov_bits & ~ev7_bits)) == 8'h00;
	endproperty
	a_toggle: assert property (p_toggle) else $error("overflow toggle missed");

	property p_fast_tof;
		fast_clear_bit && dp_valid && dp_idx == `TCC_IDX_COUNTER && !overflow |=> !counter_overflow_flag;
	endproperty
	a_fast_tof: assert property (p_fast_tof) else $error("overflow flag not fast cleared");
endmodule
`default_nettype wire

// ---- verification/tcc_chan_model.sv ----
// far-side channel logic: a compare match on channel 7 on request
// assumes: hclk domain, request from the bench one cycle long
`timescale 1ns/1ps
`default_nettype none
module tcc_chan_model (
	input  wire logic          hclk,
	input  wire logic          fire,
	output tcc_pkg::tcc_byte_t match
);
	import tcc_pkg::*;
	// registered so the pulse never races the bench drive
	always @(posedge hclk) begin
		match <= {fire, 7'h00};
	end
endmodule
`default_nettype wire

// ---- verification/test_timer_counter_control_core.sv ----
// bench for the timer counter control core, zero-wait ahb-lite master
// assumes: counter tick every cycle with legacy prescale field zero
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"
module test_timer_counter_control_core;
	import tcc_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, tm, wm, fm, fire;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	tcc_word_t   hrdata, rd, r1;
	logic        hrdy, hresp, ovf, pa_ev;
	tcc_byte_t   pin, oe_n, match;
	int          errors, n_checks, n;
	tcc_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .test_mode(tm), .wait_mode(wm),
		.freeze_mode(fm), .compare_match(match), .capture_event(8'h00),
		.chan_action(8'h00), .chan_action_level(8'h00), .pa_overflow_event(pa_ev),
		.pa_input_event(pa_ev), .timer_pin_out(pin), .timer_pin_oe_n(oe_n),
		.main_counter(), .count_tick(), .pa_div64_tick(), .channel_compare_select(),
		.channel_event_flag(), .counter_overflow_flag(ovf),
		.pulse_accum_overflow_flag(), .pulse_accum_input_flag());
	tcc_chan_model model_u (.hclk(hclk), .fire(fire), .match(match));
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic xfer(logic wr, logic [7:0] idx, logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	task automatic ovf_wait;
		tm <= 1'b1;
		xfer(1'b1, `TCC_IDX_COUNTER, 32'h0000_fff0);
		tm <= 1'b0;
		repeat (40) if (ovf !== 1'b1) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_write_lock;
		chk("oe_n", 32'h0000_00ff, {24'h0, oe_n});
		chk("hresp", 32'h0, {31'h0, hresp});
		xfer(1'b1, `TCC_IDX_COUNTER, 32'h0000_1234);
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		chk("cnt normal", 32'h0, rd);
		tm <= 1'b1;
		xfer(1'b1, `TCC_IDX_COUNTER, 32'h0000_1234);
		tm <= 1'b0;
		repeat (5) @(posedge hclk);
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		chk("cnt held", 32'h0000_1234, rd);
		xfer(1'b0, 8'h3f, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask
	task automatic t_count_up;
		xfer(1'b1, `TCC_IDX_CONTROL_ONE, 32'h0000_0080);
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		r1 = rd;
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		chk("cnt up", 32'h1, {31'h0, rd[15:0] > r1[15:0]});
		xfer(1'b1, `TCC_IDX_CONTROL_ONE, 32'h0000_0088);
		xfer(1'b0, `TCC_IDX_CONTROL_ONE, 32'h0);
		chk("prec lock", 32'h0000_0080, rd);
	endtask
	task automatic t_modes;
		xfer(1'b1, `TCC_IDX_CONTROL_ONE, 32'h0000_00a0);
		fm <= 1'b1;
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		r1 = rd;
		xfer(1'b0, `TCC_IDX_COUNTER, 32'h0);
		chk("freeze", r1, rd);
		fm <= 1'b0;
		xfer(1'b1, `TCC_IDX_CONTROL_ONE, 32'h0000_00c0);
		wm <= 1'b1;
		repeat (2) @(posedge hclk);
		n = 0;
		repeat (130) @(posedge hclk) n += dut_u.pa_div64_tick;
		chk("div64 wait", 32'h0, n);
		wm <= 1'b0;
		repeat (2) @(posedge hclk);
		n = 0;
		repeat (130) @(posedge hclk) n += dut_u.pa_div64_tick;
		chk("div64 run", 32'h1, {31'h0, n >= 2});
	endtask
	task automatic t_ovf_toggle;
		xfer(1'b1, `TCC_IDX_SELECT, 32'h0000_0001);
		xfer(1'b1, `TCC_IDX_TOGGLE, 32'h0000_0001);
		ovf_wait();
		chk("ovf set", 32'h1, {31'h0, ovf});
		chk("pin0 toggled", 32'h1, {31'h0, pin[0]});
		xfer(1'b1, `TCC_IDX_OVF_FLAGS, 32'h0);
		chk("w0 keeps", 32'h1, {31'h0, ovf});
		xfer(1'b1, `TCC_IDX_OVF_FLAGS, 32'h0000_0080);
		@(posedge hclk);
		chk("w1 clears", 32'h0, {31'h0, ovf});
	endtask
	task automatic t_chan7;
		xfer(1'b1, `TCC_IDX_EV7_MASK, 32'h0000_0006);
		xfer(1'b1, `TCC_IDX_EV7_DATA, 32'h0000_0006);
		xfer(1'b1, `TCC_IDX_SELECT, 32'h0000_0083);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("pins", 32'h0000_0003, {24'h0, pin[2:0]});
		chk("oe_n", 32'h0000_007c, {24'h0, oe_n});
	endtask
	task automatic t_fast_clear;
		ovf_wait();
		xfer(1'b1, `TCC_IDX_CONTROL_ONE, 32'h0000_0090);
		chk("ovf pre", 32'h1, {31'h0, ovf});
		xfer(1'b0, `TCC_IDX_COUNTER_LO, 32'h0);
		@(posedge hclk);
		chk("fast clr", 32'h0, {31'h0, ovf});
		xfer(1'b0, `TCC_IDX_CHAN_FLAGS, 32'h0);
		chk("ch7 flag", 32'h0000_0080, rd);
		xfer(1'b1, 8'h1e, 32'h0);
		xfer(1'b0, `TCC_IDX_CHAN_FLAGS, 32'h0);
		chk("ch fast clr", 32'h0, rd);
		pa_ev <= 1'b1;
		@(posedge hclk);
		pa_ev <= 1'b0;
		xfer(1'b0, `TCC_IDX_PA_FLAGS, 32'h0);
		chk("pa flags set", 32'h0000_0003, rd);
		xfer(1'b0, `TCC_IDX_PA_COUNT_HI, 32'h0);
		xfer(1'b0, `TCC_IDX_PA_FLAGS, 32'h0);
		chk("pa fast clr", 32'h0, rd);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		{hresetn, hsel, hwrite, tm, wm, fm, fire, pa_ev, htrans} = '0;
		{haddr, hwdata, errors, n_checks} = '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_write_lock();
		t_count_up();
		t_modes();
		t_ovf_toggle();
		t_chan7();
		t_fast_clear();
		final_report();
	end
endmodule
`default_nettype wire
